//--- logic/tlp_core.sv
// Register bank and PWM core of the thirty-channel LED driver
`timescale 1ns/1ps
module tlp_core (
	input  wire logic         CORE_CLK,
	input  wire logic         RESET,
	input  wire logic         SCL,
	input  wire logic         SDA_IN,
	output      logic         SDA_OUT,
	output      logic         SDA_OE,
	input  wire logic [1:0]   ADDR_STRAP,
	input  wire logic         SHUTDOWN_PIN_N,
	output      logic [29:0]  CHANNEL_ON,
	output      logic [239:0] CHANNEL_SCALE,
	output      logic [7:0]   GLOBAL_FACTOR,
	output      logic [2:0]   OSC_FREQ_SELECT,
	output      logic         DEVICE_ACTIVE
);
	// Whole register bank plus the period counter
	typedef struct packed {
		logic [7:0]        ctrl;                // Power and clock control
		logic [29:0][15:0] duty_shadow;         // Written duty values
		logic [29:0][15:0] duty_active;         // Duty values in use
		logic [29:0][7:0]  scale;               // Per-channel current scale
		logic [7:0]        global_current_factor;                 // Global current factor
		logic [7:0]        phase;               // Phase stagger control
		logic [7:0]        fault_en;            // Fault detection enable, stored only
		logic [4:0][7:0]   fault;               // Fault status bytes, stored only
		logic [7:0]        thermal;             // Thermal status, stored only
		logic [7:0]        dither;              // Clock dither control, stored only
		logic [8:0]        presc;               // Oscillator prescaler
		logic [15:0]       count;               // Free-running period counter
	} tlp_core_type;

	tlp_core_type st;                           // Current state
	tlp_core_type next_st;                      // Next state
	logic [7:0]   ptr;                          // Bus register pointer
	logic [7:0]   rd_data;                      // Byte at the pointer
	logic         wr_pulse;                     // One-cycle write strobe
	logic [7:0]   wr_addr;                      // Register written
	logic [7:0]   wr_data;                      // Byte written
	logic         running;                      // Both shutdown controls released
	logic [1:0]   res;                          // Selected resolution
	logic [2:0]   osc;                          // Selected oscillator code
	logic         tick;                         // Oscillator step
	logic [6:0]   duty_hit;                     // {valid, high, channel} for writes
	logic [5:0]   scale_hit;                    // {valid, channel} for writes
	logic [6:0]   duty_rd;                      // Same decode for the pointer
	logic [5:0]   scale_rd;                     // Same decode for the pointer

	// Duty address to {valid, high byte, channel}
	function automatic logic [6:0] duty_slot(input logic [7:0] addr);
		logic [6:0] slot;
		logic [7:0] off;
		slot = 7'h00;
		off = 8'h00;
		for (int r = 0; r < 4; r++) begin
			if (addr >= tlp_pkg::DUTY_FIRST[r] && addr <= tlp_pkg::DUTY_LAST[r]) begin
				off = 8'(addr - tlp_pkg::DUTY_FIRST[r]);
				// Even offset from an odd start is the low byte
				slot = {1'b1, off[0], 5'(off[5:1] + tlp_pkg::RANGE_BASE[r])};
			end
		end
		return slot;
	endfunction

	// Scale address to {valid, channel}
	function automatic logic [5:0] scale_slot(input logic [7:0] addr);
		logic [5:0] slot;
		logic [7:0] off;
		slot = 6'h00;
		off = 8'h00;
		for (int r = 0; r < 4; r++) begin
			if (addr >= tlp_pkg::SCALE_FIRST[r] && addr <= tlp_pkg::SCALE_LAST[r]) begin
				off = 8'(addr - tlp_pkg::SCALE_FIRST[r]);
				slot = {1'b1, 5'(off[4:0] + tlp_pkg::RANGE_BASE[r])};
			end
		end
		return slot;
	endfunction

	// Serial register access
	tlp_bus_slave u_bus (
		.clk      (CORE_CLK),
		.reset    (RESET),
		.scl      (SCL),
		.sda_in   (SDA_IN),
		.sda_out  (SDA_OUT),
		.sda_oe   (SDA_OE),
		.strap    (ADDR_STRAP),
		.rd_data  (rd_data),
		.ptr      (ptr),
		.wr_pulse (wr_pulse),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data)
	);

	// Decoded control fields
	always_comb begin
		running = SHUTDOWN_PIN_N && st.ctrl[tlp_pkg::CTRL_SSD_BIT];
		res = st.ctrl[tlp_pkg::CTRL_RES_LSB +: 2];
		osc = st.ctrl[tlp_pkg::CTRL_OSC_LSB +: 3];
		// Larger codes divide further, so 000 is fastest
		tick = (st.presc == tlp_pkg::OSC_LAST[osc]);
		duty_hit = duty_slot(wr_addr);
		scale_hit = scale_slot(wr_addr);
		duty_rd = duty_slot(ptr);
		scale_rd = scale_slot(ptr);
	end

	// Read mux; strobe registers and gaps read zero
	always_comb begin
		rd_data = 8'h00;
		if (duty_rd[6]) begin
			rd_data = duty_rd[5] ? st.duty_shadow[duty_rd[4:0]][15:8] : st.duty_shadow[duty_rd[4:0]][7:0];
		end else if (scale_rd[5]) begin
			rd_data = st.scale[scale_rd[4:0]];
		end else if (ptr >= tlp_pkg::ADDR_FAULT_FIRST && ptr < tlp_pkg::ADDR_THERMAL) begin
			rd_data = st.fault[3'(ptr - tlp_pkg::ADDR_FAULT_FIRST)];
		end else begin
			case (ptr)
				tlp_pkg::ADDR_CTRL: begin
					rd_data = st.ctrl;
				end
				tlp_pkg::ADDR_GCC: begin
					rd_data = st.global_current_factor;
				end
				tlp_pkg::ADDR_PHASE: begin
					rd_data = st.phase;
				end
				tlp_pkg::ADDR_FAULT_EN: begin
					rd_data = st.fault_en;
				end
				tlp_pkg::ADDR_THERMAL: begin
					rd_data = st.thermal;
				end
				tlp_pkg::ADDR_DITHER: begin
					rd_data = st.dither;
				end
				// Update and reset registers give nothing back
				default: begin
					rd_data = 8'h00;
				end
			endcase
		end
	end

	// Period counter and register writes
	always_comb begin
		next_st = st;
		// Counter rests at zero in shutdown; the run input of each channel keeps outputs dark
		if (!running) begin
			next_st.presc = 9'h000;
			next_st.count = tlp_pkg::RESET_WORD;
		end else if (tick) begin
			next_st.presc = 9'h000;
			// Period is the step count, so rate is oscillator over steps
			if (st.count >= tlp_pkg::RES_MASK[res]) begin
				next_st.count = tlp_pkg::RESET_WORD;
			end else begin
				next_st.count = 16'(st.count + 16'h0001);
			end
		end else begin
			next_st.presc = 9'(st.presc + 9'h001);
		end
		if (wr_pulse) begin
			if (duty_hit[6]) begin
				// Shadow only; outputs wait for the strobe
				if (duty_hit[5]) begin
					next_st.duty_shadow[duty_hit[4:0]][15:8] = wr_data;
				end else begin
					next_st.duty_shadow[duty_hit[4:0]][7:0] = wr_data;
				end
			end else if (scale_hit[5]) begin
				next_st.scale[scale_hit[4:0]] = wr_data;
			end else if (wr_addr >= tlp_pkg::ADDR_FAULT_FIRST && wr_addr < tlp_pkg::ADDR_THERMAL) begin
				next_st.fault[3'(wr_addr - tlp_pkg::ADDR_FAULT_FIRST)] = wr_data;
			end else begin
				case (wr_addr)
					tlp_pkg::ADDR_CTRL: begin
						next_st.ctrl = wr_data & tlp_pkg::CTRL_MASK;
					end
					tlp_pkg::ADDR_UPDATE: begin
						// Ignored unless both shutdown controls are released
						if (wr_data == tlp_pkg::STROBE_VALUE && running) begin
							next_st.duty_active = st.duty_shadow;
						end
					end
					tlp_pkg::ADDR_GCC: begin
						next_st.global_current_factor = wr_data;
					end
					tlp_pkg::ADDR_PHASE: begin
						next_st.phase = wr_data & tlp_pkg::PHASE_MASK;
					end
					tlp_pkg::ADDR_FAULT_EN: begin
						next_st.fault_en = wr_data;
					end
					tlp_pkg::ADDR_THERMAL: begin
						next_st.thermal = wr_data;
					end
					tlp_pkg::ADDR_DITHER: begin
						next_st.dither = wr_data;
					end
					tlp_pkg::ADDR_RESTORE: begin
						// Also clears the counter, so the restart is clean
						if (wr_data == tlp_pkg::STROBE_VALUE) begin
							next_st = '0;
						end
					end
					// Gaps between ranges take no write
					default: begin
						next_st.ctrl = next_st.ctrl;
					end
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// One compare per channel; phase follows channel index modulo six
	for (genvar ch = 0; ch < tlp_pkg::NUM_CHANNELS; ch++) begin : g_chan
		tlp_channel #(
			.PHASE (ch % 6)
		) u_chan (
			.clk     (CORE_CLK),
			.reset   (RESET),
			.run     (running),
			.stagger (st.phase[tlp_pkg::PHASE_EN_BIT]),
			.res     (res),
			.count   (st.count),
			.duty    (st.duty_active[ch]),
			.on      (CHANNEL_ON[ch])
		);
	end

	// Current setting leaves as register values for the analog stage
	assign CHANNEL_SCALE = st.scale;
	assign GLOBAL_FACTOR = st.global_current_factor;
	assign OSC_FREQ_SELECT = osc;
	assign DEVICE_ACTIVE = running;
endmodule // tlp_core

//--- logic/tlp_pkg.sv
// Shared constants of the thirty-channel LED PWM core
package tlp_pkg;
	localparam int NUM_CHANNELS = 30;                           // Driven outputs
	localparam int NUM_FAULT_REGS = 5;                          // Fault status bytes
	localparam logic [4:0] BUS_ADDR_FIXED = 5'h0d;              // Upper bus address bits 01101
	localparam logic [7:0] STROBE_VALUE = 8'h00;                // Only value that acts on strobe registers
	localparam logic [7:0] RESET_BYTE = 8'h00;                  // Reset value of every byte register
	localparam logic [15:0] RESET_WORD = 16'h0000;              // Reset value of duty words
	// Register offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_UPDATE = 8'h49;
	localparam logic [7:0] ADDR_GCC = 8'h6e;
	localparam logic [7:0] ADDR_PHASE = 8'h70;
	localparam logic [7:0] ADDR_FAULT_EN = 8'h71;
	localparam logic [7:0] ADDR_FAULT_FIRST = 8'h72;
	localparam logic [7:0] ADDR_THERMAL = 8'h77;
	localparam logic [7:0] ADDR_DITHER = 8'h78;
	localparam logic [7:0] ADDR_RESTORE = 8'h7f;
	// Duty and scale ranges: first, last, first channel index
	localparam logic [3:0][7:0] DUTY_FIRST = {8'h3d, 8'h27, 8'h0f, 8'h03};
	localparam logic [3:0][7:0] DUTY_LAST = {8'h46, 8'h3a, 8'h22, 8'h0c};
	localparam logic [3:0][7:0] SCALE_FIRST = {8'h68, 8'h5d, 8'h51, 8'h4b};
	localparam logic [3:0][7:0] SCALE_LAST = {8'h6c, 8'h66, 8'h5a, 8'h4f};
	localparam logic [3:0][4:0] RANGE_BASE = {5'h19, 5'h0f, 5'h05, 5'h00};
	// Field positions and writable masks
	localparam int CTRL_SSD_BIT = 0;
	localparam int CTRL_RES_LSB = 1;
	localparam int CTRL_OSC_LSB = 4;
	localparam int PHASE_EN_BIT = 7;
	localparam logic [7:0] CTRL_MASK = 8'h77;
	localparam logic [7:0] PHASE_MASK = 8'hbf;
	// Resolution codes, counter masks and sixth-of-period phase steps
	localparam logic [1:0] RES_8 = 2'h0;
	localparam logic [1:0] RES_10 = 2'h1;
	localparam logic [1:0] RES_12 = 2'h2;
	localparam logic [1:0] RES_16 = 2'h3;
	localparam logic [3:0][15:0] RES_MASK = {16'hffff, 16'h0fff, 16'h03ff, 16'h00ff};
	localparam logic [3:0][15:0] PHASE_STEP = {16'h2aaa, 16'h02aa, 16'h00aa, 16'h002a};
	// Oscillator prescaler terminal counts, code 0 fastest
	localparam logic [7:0][8:0] OSC_LAST = {9'h1ff, 9'h0ff, 9'h07f, 9'h03f, 9'h01f, 9'h00f, 9'h001, 9'h000};
	// Bus engine states
	typedef enum logic [3:0] {
		BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_REG, BUS_ACK_REG,
		BUS_WDATA, BUS_ACK_W, BUS_RDATA, BUS_MACK
	} bus_state_type;
endpackage

//--- logic/tlp_channel.sv
// One PWM output compare with phase offset
`timescale 1ns/1ps
module tlp_channel #(
	parameter int PHASE = 0
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        run,
	input  wire logic        stagger,
	input  wire logic [1:0]  res,
	input  wire logic [15:0] count,
	input  wire logic [15:0] duty,
	output      logic        on
);
	typedef struct packed {
		logic on;                       // Registered output level
	} tlp_chan_type;

	tlp_chan_type st;                   // Current state
	tlp_chan_type next_st;              // Next state
	logic [15:0]  offset;               // Phase shift of the compare
	logic [15:0]  shifted;              // Counter seen by this channel
	logic [15:0]  level;                // Duty limited to its low byte at eight bits

	// Compare shifted counter against duty
	always_comb begin
		offset = stagger ? 16'(16'(PHASE) * tlp_pkg::PHASE_STEP[res]) : 16'h0000;
		shifted = 16'(count + offset) & tlp_pkg::RES_MASK[res];
		// Only the low byte counts at eight bits
		level = (res == tlp_pkg::RES_8) ? {8'h00, duty[7:0]} : duty;
		next_st.on = run && (shifted < level);
	end

	// State register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign on = st.on;
endmodule // tlp_channel

//--- logic/tlp_bus_slave.sv
// Two-wire serial slave with auto-incrementing register pointer
`timescale 1ns/1ps
module tlp_bus_slave (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output      logic       sda_out,
	output      logic       sda_oe,
	input  wire logic [1:0] strap,
	input  wire logic [7:0] rd_data,
	output      logic [7:0] ptr,
	output      logic       wr_pulse,
	output      logic [7:0] wr_addr,
	output      logic [7:0] wr_data
);
	typedef struct packed {
		tlp_pkg::bus_state_type state; // Engine state
		logic [2:0]             bits;  // Bit counter
		logic [7:0]             shift; // Byte shift register
		logic [7:0]             ptr;   // Register pointer
		logic                   got;   // Acknowledge already driven
		logic                   oe;    // Pulling data low
		logic                   scl_q; // Previous clock line
		logic                   sda_q; // Previous data line
		logic                   wr;    // Write strobe
		logic [7:0]             waddr; // Address of the write
		logic [7:0]             wdata; // Data of the write
	} tlp_bus_type;

	tlp_bus_type st;
	tlp_bus_type next_st;
	logic rise;
	logic fall;
	logic start;
	logic stop;

	// Line events and byte engine
	always_comb begin
		next_st = st;
		next_st.scl_q = scl;
		next_st.sda_q = sda_in;
		next_st.wr = 1'b0;
		rise = scl && !st.scl_q;
		fall = !scl && st.scl_q;
		start = scl && st.scl_q && st.sda_q && !sda_in;
		stop = scl && st.scl_q && !st.sda_q && sda_in;
		if (start) begin
			// Also covers the repeated start of a read
			next_st.state = tlp_pkg::BUS_ADDR;
			next_st.bits = 3'h0;
			next_st.oe = 1'b0;
		end else if (stop) begin
			next_st.state = tlp_pkg::BUS_IDLE;
			next_st.oe = 1'b0;
		end else begin
			case (st.state)
				tlp_pkg::BUS_ADDR, tlp_pkg::BUS_REG, tlp_pkg::BUS_WDATA: begin
					if (rise) begin
						next_st.shift = {st.shift[6:0], sda_in};
						next_st.bits = 3'(st.bits + 3'h1);
						next_st.got = 1'b0;
						if (st.bits == 3'h7) begin
							if (st.state == tlp_pkg::BUS_REG) begin
								next_st.state = tlp_pkg::BUS_ACK_REG;
							end else if (st.state == tlp_pkg::BUS_WDATA) begin
								next_st.state = tlp_pkg::BUS_ACK_W;
							end else if ({st.shift[6:2], st.shift[1:0]} == {tlp_pkg::BUS_ADDR_FIXED, strap}) begin
								next_st.state = tlp_pkg::BUS_ACK_ADDR;
							end else begin
								// Someone else is addressed
								next_st.state = tlp_pkg::BUS_IDLE;
							end
						end
					end
				end
				tlp_pkg::BUS_ACK_ADDR, tlp_pkg::BUS_ACK_REG, tlp_pkg::BUS_ACK_W: begin
					if (fall && !st.got) begin
						next_st.got = 1'b1;
						next_st.oe = 1'b1;
					end else if (fall) begin
						next_st.oe = 1'b0;
						next_st.bits = 3'h0;
						if (st.state == tlp_pkg::BUS_ACK_REG) begin
							next_st.ptr = st.shift;
							next_st.state = tlp_pkg::BUS_WDATA;
						end else if (st.state == tlp_pkg::BUS_ACK_W) begin
							next_st.wr = 1'b1;
							next_st.waddr = st.ptr;
							next_st.wdata = st.shift;
							next_st.ptr = 8'(st.ptr + 8'h01);
							next_st.state = tlp_pkg::BUS_WDATA;
						end else if (st.shift[0]) begin
							// Direction bit 1: first read byte
							next_st.shift = rd_data;
							next_st.oe = !rd_data[7];
							next_st.state = tlp_pkg::BUS_RDATA;
						end else begin
							next_st.state = tlp_pkg::BUS_REG;
						end
					end
				end
				tlp_pkg::BUS_RDATA: begin
					if (fall && st.bits == 3'h7) begin
						next_st.oe = 1'b0;
						next_st.got = 1'b0;
						next_st.state = tlp_pkg::BUS_MACK;
					end else if (fall) begin
						next_st.bits = 3'(st.bits + 3'h1);
						next_st.shift = {st.shift[6:0], 1'b0};
						next_st.oe = !st.shift[6];
					end
				end
				tlp_pkg::BUS_MACK: begin
					if (rise) begin
						// Master acknowledge asks for another byte
						next_st.got = !sda_in;
						next_st.ptr = 8'(st.ptr + 8'h01);
					end else if (fall && st.got) begin
						next_st.shift = rd_data;
						next_st.oe = !rd_data[7];
						next_st.bits = 3'h0;
						next_st.state = tlp_pkg::BUS_RDATA;
					end else if (fall) begin
						next_st.state = tlp_pkg::BUS_IDLE;
					end
				end
				default: begin
					next_st.oe = 1'b0;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= '0;
			// Line history starts at the idle level, so no false edge follows reset
			st.scl_q <= 1'b1;
			st.sda_q <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = st.oe;
	assign ptr = st.ptr;
	assign wr_pulse = st.wr;
	assign wr_addr = st.waddr;
	assign wr_data = st.wdata;
endmodule // tlp_bus_slave

//--- dv/tlp_core_chk.sv
// Port-level assertions of the LED PWM core
`timescale 1ns/1ps
module tlp_core_chk (
	input wire logic         CORE_CLK,
	input wire logic         RESET,
	input wire logic         SCL,
	input wire logic         SDA_OUT,
	input wire logic         SDA_OE,
	input wire logic         SHUTDOWN_PIN_N,
	input wire logic [29:0]  CHANNEL_ON,
	input wire logic [239:0] CHANNEL_SCALE,
	input wire logic [7:0]   GLOBAL_FACTOR,
	input wire logic [2:0]   OSC_FREQ_SELECT,
	input wire logic         DEVICE_ACTIVE
);
	// Single domain, so one clock and one disable for all
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	// Open drain only ever pulls low
	a_sda_drain: assert property (SDA_OUT == 1'b0) else $error("sda driven high");
	// Data line moves only in a low clock phase, else it would fake a start or stop
	a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL && !$past(SCL)) else $error("sda moved, scl high");
	// A pull-down lasts at least three clock cycles
	a_ack_hold: assert property ($rose(SDA_OE) |-> SDA_OE [*3]) else $error("pull-down too short");
	// Pin low always wins over the control bit
	a_pin_gates: assert property (!SHUTDOWN_PIN_N |-> !DEVICE_ACTIVE) else $error("active with pin low");
	// Shutdown keeps every output dark
	a_dark_off: assert property (!DEVICE_ACTIVE [*2] |=> CHANNEL_ON == '0) else $error("output on in shutdown");
	// Output 0 can only light while running
	a_on_needs_run: assert property ($rose(CHANNEL_ON[0]) |-> $past(DEVICE_ACTIVE) || $past(DEVICE_ACTIVE, 2))
		else $error("output lit while stopped");
	// Current, oscillator and shutdown settings move only just after a write acknowledge ends
	a_scale_timed: assert property ($changed({CHANNEL_SCALE, GLOBAL_FACTOR}) |-> !SDA_OE
		&& ($past(SDA_OE, 2) || $past(SDA_OE, 3))) else $error("scale moved without write");
	a_osc_timed: assert property ($changed(OSC_FREQ_SELECT) |-> $past(SDA_OE, 2) || $past(SDA_OE, 3))
		else $error("oscillator moved without write");
	a_ssd_timed: assert property ($changed(DEVICE_ACTIVE) && $stable(SHUTDOWN_PIN_N) |-> !SDA_OE
		&& ($past(SDA_OE, 2) || $past(SDA_OE, 3))) else $error("shutdown bit moved without write");
	// Main scenarios reached
	c_lit: cover property ($rose(CHANNEL_ON[0]));
	c_ack: cover property ($rose(SDA_OE));
	c_stop: cover property ($fell(DEVICE_ACTIVE));
endmodule // tlp_core_chk

bind tlp_core tlp_core_chk u_chk (.CORE_CLK(CORE_CLK), .RESET(RESET), .SCL(SCL), .SDA_OUT(SDA_OUT),
	.SDA_OE(SDA_OE), .SHUTDOWN_PIN_N(SHUTDOWN_PIN_N), .CHANNEL_ON(CHANNEL_ON), .CHANNEL_SCALE(CHANNEL_SCALE),
	.GLOBAL_FACTOR(GLOBAL_FACTOR), .OSC_FREQ_SELECT(OSC_FREQ_SELECT), .DEVICE_ACTIVE(DEVICE_ACTIVE));

//--- dv/tlp_master.sv
// Two-wire bus master model facing the core
`timescale 1ns/1ps
module tlp_master (
	input  wire logic       clk,
	input  wire logic       oe,
	output      logic       scl,
	output      logic       sda,
	output      logic       got,
	output      logic [7:0] got_val
);
	logic drv; // Own drive, 1 = released
	// Pull-up wired with the core's pull-down
	assign sda = drv & ~oe;
	initial begin
		scl = 1'b1;
		drv = 1'b1;
		got = 1'b0;
		got_val = 8'h00;
	end
	// One bit slot: data moves in low phase, sampled late in high phase
	task automatic bit_io(input logic d, output logic r);
		@(posedge clk) scl <= 1'b0;
		repeat (2) @(posedge clk);
		drv <= d;
		repeat (2) @(posedge clk);
		scl <= 1'b1;
		repeat (3) @(posedge clk);
		r = sda;
	endtask
	// Start (1,0) or stop (0,1): data edge while clock high
	task automatic cond(input logic a, input logic b);
		logic r;
		bit_io(a, r);
		drv <= b;
		repeat (3) @(posedge clk);
	endtask
	// Eight bits, most significant first
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
	endtask
	// Read one byte, hand it to the bench, then ack or nack
	task automatic rbyte(input logic last);
		logic [7:0] v;
		logic k;
		xfer(8'hff, v);
		@(posedge clk) begin
			got <= 1'b1;
			got_val <= v;
		end
		@(posedge clk) got <= 1'b0;
		bit_io(last, k);
	endtask
endmodule // tlp_master

//--- dv/tlp_core_bench.sv
// Self-checking bench of the LED PWM core
`timescale 1ns/1ps
module tlp_core_bench;
	logic         clk, rst, pin_n, scl, sda, so, oe, got, act;
	logic [1:0]   strap;          // Bus address strap
	logic [7:0]   got_val, global_current_factor, v1, v2, v3;
	logic [29:0]  on;
	logic [239:0] scale;
	logic [2:0]   osc;
	logic [7:0]   exp_q[$];       // Expected read bytes, oldest first
	logic [31:0]  seed = 32'h4e8026ad;
	int           err_total = 0;
	int           checked = 0;
	tlp_core dut (.CORE_CLK(clk), .RESET(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(so), .SDA_OE(oe),
		.ADDR_STRAP(strap), .SHUTDOWN_PIN_N(pin_n), .CHANNEL_ON(on), .CHANNEL_SCALE(scale),
		.GLOBAL_FACTOR(global_current_factor), .OSC_FREQ_SELECT(osc), .DEVICE_ACTIVE(act));
	tlp_master m (.clk(clk), .oe(oe), .scl(scl), .sda(sda), .got(got), .got_val(got_val));
	// Clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		cmp_val({24'h0, g}, {24'h0, e});
	endtask
	function automatic logic [7:0] baddr(input logic rw);
		return {tlp_pkg::BUS_ADDR_FIXED, strap, rw};
	endfunction
	// Send a byte and check whether it was acknowledged
	task automatic ab(input logic [7:0] b, input logic e);
		logic [7:0] x;
		logic a;
		m.xfer(b, x);
		m.bit_io(1'b1, a);
		cmp_val({31'h0, a}, {31'h0, e});
	endtask
	task automatic wr(input logic [7:0] r, input int n, input logic [39:0] d);
		m.cond(1'b1, 1'b0);
		ab(baddr(1'b0), 1'b0);
		ab(r, 1'b0);
		for (int i = 0; i < n; i++) ab(d[8*i +: 8], 1'b0);
		m.cond(1'b0, 1'b1);
		repeat (3) @(posedge clk);
	endtask
	task automatic rd(input logic [7:0] r, input int n);
		m.cond(1'b1, 1'b0);
		ab(baddr(1'b0), 1'b0);
		ab(r, 1'b0);
		m.cond(1'b1, 1'b0);
		ab(baddr(1'b1), 1'b0);
		for (int i = 0; i < n; i++) m.rbyte(i == n - 1);
		m.cond(1'b0, 1'b1);
	endtask
	// High cycles of channel 0 over a window
	task automatic count_on(input int len, input logic [31:0] e);
		logic [31:0] c;
		c = 0;
		repeat (len) @(posedge clk) c += on[0];
		cmp_val(c, e);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Read data arriving at the master against the oldest note
	always @(posedge clk) begin
		if (got === 1'b1)
			cmp_byte(got_val, exp_q.pop_front());
	end
	// Hang guard, well beyond the expected run
	initial begin
		#5000000;
		err_total++;
		results();
	end
	initial begin
		rst = 1'b1;
		strap = 2'h0;
		pin_n = 1'b0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		cmp_val(on, 0);
		cmp_val(act, 0);
		cmp_val(so, 0);
		repeat (8) exp_q.push_back(8'h00);
		rd(8'h00, 1);
		rd(8'h03, 2);
		rd(8'h6c, 5);
		$display("test reset values done");
		v1 = rnd();
		v2 = rnd();
		v3 = rnd();
		strap <= v1[1:0];
		wr(8'h6c, 5, {v3, 8'h5a, v2, 8'h33, v1});
		cmp_val(scale[239:232], v1);
		cmp_val(global_current_factor, v2);
		exp_q = '{v1, 8'h00, v2, 8'h00, v3 & 8'hbf};
		rd(8'h6c, 5);
		exp_q = '{8'h00, 8'h00, 8'h00};
		rd(8'h49, 2);
		rd(8'h7f, 1);
		$display("test burst and write-only done");
		pin_n <= 1'b1;
		for (logic [3:0] c = 0; c < 8; c++) begin
			wr(8'h00, 1, {32'h0, 1'b1, c[2:0], 1'b1, c[1:0], 1'b1});
			cmp_val(osc, c);
			cmp_val(act, 1);
			exp_q.push_back({1'b0, c[2:0], 1'b0, c[1:0], 1'b1});
			rd(8'h00, 1);
		end
		$display("test control done");
		wr(8'h00, 1, 8'h01);
		wr(8'h03, 2, {8'h77, 8'h02});
		count_on(256, 0);
		wr(8'h49, 1, 8'h00);
		count_on(256, 2);
		wr(8'h04, 1, 8'h01);
		wr(8'h00, 1, 8'h03);
		wr(8'h49, 1, 8'h00);
		count_on(1024, 258);
		$display("test duty done");
		pin_n <= 1'b0;
		wr(8'h03, 1, 8'h05);
		cmp_val(act, 0);
		wr(8'h49, 1, 8'h00);
		pin_n <= 1'b1;
		wr(8'h49, 1, 8'h01);
		count_on(1024, 258);
		$display("test refused strobe done");
		wr(8'h7f, 1, 8'h00);
		cmp_val({31'h0, |scale}, 0);
		cmp_val(global_current_factor, 0);
		cmp_val(act, 0);
		exp_q = '{8'h00, 8'h00, 8'h00};
		rd(8'h03, 2);
		rd(8'h70, 1);
		$display("test restore done");
		m.cond(1'b1, 1'b0);
		ab({5'h0e, strap, 1'b0}, 1'b1);
		m.cond(1'b0, 1'b1);
		strap <= ~strap;
		wr(8'h6e, 1, v1);
		exp_q.push_back(v1);
		rd(8'h6e, 1);
		$display("test bus address done");
		results();
	end
endmodule // tlp_core_bench
